// ### hw/afcb_consts.vh
// Constants for the page-1 coefficient byte bank slice
// Assumes a byte-wide register port with 7-bit addresses, one clock, sync reset
// How it works
// - Each high/low byte pair forms one signed 16-bit coefficient.
// - De-emphasis right numerator-one resets to F3 / 2D, read-write.
// - De-emphasis right denominator-one resets to 53 / 7E, read-write.
// - Widening attenuation resets to 7F / FF, largest positive, read-write.
// - Addresses 55 to 64 are reserved, read-only, read as zero.
// - Record high-pass left numerator-zero resets to 39 / 55, read-write.
// - Record high-pass left numerator-one high byte resets to F3, read-write.
// - Record high-pass left numerator-one low byte resets to 2D.
`ifndef AFCB_CONSTS_VH
`define AFCB_CONSTS_VH

// ************************************
// Register offsets
// ************************************
`define AFCB_ADDR_W            7
`define AFCB_DEEMPH_R_N1_HI    7'h31
`define AFCB_DEEMPH_R_N1_LO    7'h32
`define AFCB_DEEMPH_R_D1_HI    7'h33
`define AFCB_DEEMPH_R_D1_LO    7'h34
`define AFCB_WIDEN_ATT_HI      7'h35
`define AFCB_WIDEN_ATT_LO      7'h36
`define AFCB_RSVD_FIRST        7'h37
`define AFCB_RSVD_LAST         7'h40
`define AFCB_HPF_L_N0_HI       7'h41
`define AFCB_HPF_L_N0_LO       7'h42
`define AFCB_HPF_L_N1_HI       7'h43
`define AFCB_HPF_L_N1_LO       7'h44

// ************************************
// Reset values
// ************************************
`define AFCB_RST_DEEMPH_R_N1_HI 8'hF3
`define AFCB_RST_DEEMPH_R_N1_LO 8'h2D
`define AFCB_RST_DEEMPH_R_D1_HI 8'h53
`define AFCB_RST_DEEMPH_R_D1_LO 8'h7E
`define AFCB_RST_WIDEN_ATT_HI   8'h7F
`define AFCB_RST_WIDEN_ATT_LO   8'hFF
`define AFCB_RST_RSVD           8'h00
`define AFCB_RST_HPF_L_N0_HI    8'h39
`define AFCB_RST_HPF_L_N0_LO    8'h55
`define AFCB_RST_HPF_L_N1_HI    8'hF3
`define AFCB_RST_HPF_L_N1_LO    8'h2D

`endif

// ### hw/afcb_coeff_pair.v
// One coefficient held as a high and a low byte register
// Assumes the parent decodes the address into two write strobes
`timescale 1ns/1ps
`include "afcb_consts.vh"

module afcb_coeff_pair #(
  parameter [7:0] RST_HI = 8'h00,
  parameter [7:0] RST_LO = 8'h00
) (
  // Clock and reset
  input  wire        clock,
  input  wire        reset,
  // Byte writes
  input  wire        wr_hi,
  input  wire        wr_lo,
  input  wire [7:0]  wdata,
  // Assembled signed value
  output wire [15:0] coeff
);

  reg [7:0] hi_q;
  reg [7:0] lo_q;

  always @(posedge clock) begin
    if (reset) begin
      hi_q <= RST_HI;
      lo_q <= RST_LO;
    end else begin
      if (wr_hi) begin
        hi_q <= wdata;
      end
      if (wr_lo) begin
        lo_q <= wdata;
      end
    end
  end

  assign coeff = {hi_q, lo_q};

endmodule

// ### hw/afcb_bank.v
// Coefficient byte bank: register port, storage and assembled coefficients
// Assumes a synchronous byte register port; reads answer one cycle later
`timescale 1ns/1ps
`include "afcb_consts.vh"

module afcb_bank (
  // Clock and reset
  input  wire        clock,
  input  wire        reset,
  // Register port
  input  wire [6:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  // Coefficients to the filters
  output reg  [15:0] deemph_r_numerator_one,
  output reg  [15:0] deemph_r_denominator_one,
  output reg  [15:0] widen_atten,
  output reg  [15:0] hpf_l_numerator_zero,
  output reg  [15:0] hpf_l_numerator_one
);

  // ************************************
  // Address decode
  // ************************************
  function hit;
    input [6:0] a;
    input [6:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  // Reserved window reads as zero and holds no state
  function is_rsvd;
    input [6:0] a;
    begin
      is_rsvd = (a >= `AFCB_RSVD_FIRST) && (a <= `AFCB_RSVD_LAST);
    end
  endfunction

  // Only the ten coefficient bytes hold state
  function is_mapped;
    input [6:0] a;
    begin
      is_mapped = ((a >= `AFCB_DEEMPH_R_N1_HI) && (a <= `AFCB_WIDEN_ATT_LO)) ||
                  ((a >= `AFCB_HPF_L_N0_HI) && (a <= `AFCB_HPF_L_N1_LO));
    end
  endfunction

  // Upper or lower byte of an assembled coefficient
  function [7:0] byte_of;
    input [15:0] c;
    input        take_hi;
    begin
      byte_of = take_hi ? c[15:8] : c[7:0];
    end
  endfunction

  // Passes a byte only while its select is high
  function [7:0] gate;
    input       sel;
    input [7:0] b;
    begin
      gate = sel ? b : 8'h00;
    end
  endfunction

  // Reset value of a coefficient from its two bytes
  function [15:0] rst_pair;
    input [7:0] hi;
    input [7:0] lo;
    begin
      rst_pair = {hi, lo};
    end
  endfunction

  // ************************************
  // Common selects
  // ************************************
  wire sel_rsvd;
  wire sel_mapped;
  wire wr_ok;

  assign sel_rsvd   = is_rsvd(reg_addr);
  assign sel_mapped = is_mapped(reg_addr);
  // Writes to reserved or unmapped addresses are dropped here
  assign wr_ok      = reg_wr && sel_mapped;

  // ************************************
  // De-emphasis right numerator-one
  // ************************************
  wire        sel_dn1_hi;
  wire        sel_dn1_lo;
  wire        wr_dn1_hi;
  wire        wr_dn1_lo;
  wire [15:0] dn1;

  assign sel_dn1_hi = hit(reg_addr, `AFCB_DEEMPH_R_N1_HI);
  assign sel_dn1_lo = hit(reg_addr, `AFCB_DEEMPH_R_N1_LO);
  assign wr_dn1_hi  = wr_ok && sel_dn1_hi;
  assign wr_dn1_lo  = wr_ok && sel_dn1_lo;

  // Each byte takes effect on its own, no paired update
  afcb_coeff_pair #(
    .RST_HI (`AFCB_RST_DEEMPH_R_N1_HI),
    .RST_LO (`AFCB_RST_DEEMPH_R_N1_LO)
  ) u_dn1 (
    .clock (clock),
    .reset (reset),
    .wr_hi (wr_dn1_hi),
    .wr_lo (wr_dn1_lo),
    .wdata (reg_wdata),
    .coeff (dn1)
  );

  // Output flop lags the byte registers by one cycle
  always @(posedge clock) begin
    if (reset) begin
      deemph_r_numerator_one <= rst_pair(`AFCB_RST_DEEMPH_R_N1_HI, `AFCB_RST_DEEMPH_R_N1_LO);
    end else begin
      deemph_r_numerator_one <= dn1;
    end
  end

  // ************************************
  // De-emphasis right denominator-one
  // ************************************
  wire        sel_dd1_hi;
  wire        sel_dd1_lo;
  wire        wr_dd1_hi;
  wire        wr_dd1_lo;
  wire [15:0] dd1;

  assign sel_dd1_hi = hit(reg_addr, `AFCB_DEEMPH_R_D1_HI);
  assign sel_dd1_lo = hit(reg_addr, `AFCB_DEEMPH_R_D1_LO);
  assign wr_dd1_hi  = wr_ok && sel_dd1_hi;
  assign wr_dd1_lo  = wr_ok && sel_dd1_lo;

  afcb_coeff_pair #(
    .RST_HI (`AFCB_RST_DEEMPH_R_D1_HI),
    .RST_LO (`AFCB_RST_DEEMPH_R_D1_LO)
  ) u_dd1 (
    .clock (clock),
    .reset (reset),
    .wr_hi (wr_dd1_hi),
    .wr_lo (wr_dd1_lo),
    .wdata (reg_wdata),
    .coeff (dd1)
  );

  always @(posedge clock) begin
    if (reset) begin
      deemph_r_denominator_one <= rst_pair(`AFCB_RST_DEEMPH_R_D1_HI, `AFCB_RST_DEEMPH_R_D1_LO);
    end else begin
      deemph_r_denominator_one <= dd1;
    end
  end

  // ************************************
  // Widening attenuation
  // ************************************
  wire        sel_wat_hi;
  wire        sel_wat_lo;
  wire        wr_wat_hi;
  wire        wr_wat_lo;
  wire [15:0] wat;

  assign sel_wat_hi = hit(reg_addr, `AFCB_WIDEN_ATT_HI);
  assign sel_wat_lo = hit(reg_addr, `AFCB_WIDEN_ATT_LO);
  assign wr_wat_hi  = wr_ok && sel_wat_hi;
  assign wr_wat_lo  = wr_ok && sel_wat_lo;

  afcb_coeff_pair #(
    .RST_HI (`AFCB_RST_WIDEN_ATT_HI),
    .RST_LO (`AFCB_RST_WIDEN_ATT_LO)
  ) u_wat (
    .clock (clock),
    .reset (reset),
    .wr_hi (wr_wat_hi),
    .wr_lo (wr_wat_lo),
    .wdata (reg_wdata),
    .coeff (wat)
  );

  always @(posedge clock) begin
    if (reset) begin
      widen_atten <= rst_pair(`AFCB_RST_WIDEN_ATT_HI, `AFCB_RST_WIDEN_ATT_LO);
    end else begin
      widen_atten <= wat;
    end
  end

  // ************************************
  // Record high-pass left numerator-zero
  // ************************************
  wire        sel_hn0_hi;
  wire        sel_hn0_lo;
  wire        wr_hn0_hi;
  wire        wr_hn0_lo;
  wire [15:0] hn0;

  assign sel_hn0_hi = hit(reg_addr, `AFCB_HPF_L_N0_HI);
  assign sel_hn0_lo = hit(reg_addr, `AFCB_HPF_L_N0_LO);
  assign wr_hn0_hi  = wr_ok && sel_hn0_hi;
  assign wr_hn0_lo  = wr_ok && sel_hn0_lo;

  afcb_coeff_pair #(
    .RST_HI (`AFCB_RST_HPF_L_N0_HI),
    .RST_LO (`AFCB_RST_HPF_L_N0_LO)
  ) u_hn0 (
    .clock (clock),
    .reset (reset),
    .wr_hi (wr_hn0_hi),
    .wr_lo (wr_hn0_lo),
    .wdata (reg_wdata),
    .coeff (hn0)
  );

  always @(posedge clock) begin
    if (reset) begin
      hpf_l_numerator_zero <= rst_pair(`AFCB_RST_HPF_L_N0_HI, `AFCB_RST_HPF_L_N0_LO);
    end else begin
      hpf_l_numerator_zero <= hn0;
    end
  end

  // ************************************
  // Record high-pass left numerator-one
  // ************************************
  wire        sel_hn1_hi;
  wire        sel_hn1_lo;
  wire        wr_hn1_hi;
  wire        wr_hn1_lo;
  wire [15:0] hn1;

  assign sel_hn1_hi = hit(reg_addr, `AFCB_HPF_L_N1_HI);
  assign sel_hn1_lo = hit(reg_addr, `AFCB_HPF_L_N1_LO);
  assign wr_hn1_hi  = wr_ok && sel_hn1_hi;
  assign wr_hn1_lo  = wr_ok && sel_hn1_lo;

  afcb_coeff_pair #(
    .RST_HI (`AFCB_RST_HPF_L_N1_HI),
    .RST_LO (`AFCB_RST_HPF_L_N1_LO)
  ) u_hn1 (
    .clock (clock),
    .reset (reset),
    .wr_hi (wr_hn1_hi),
    .wr_lo (wr_hn1_lo),
    .wdata (reg_wdata),
    .coeff (hn1)
  );

  always @(posedge clock) begin
    if (reset) begin
      hpf_l_numerator_one <= rst_pair(`AFCB_RST_HPF_L_N1_HI, `AFCB_RST_HPF_L_N1_LO);
    end else begin
      hpf_l_numerator_one <= hn1;
    end
  end

  // ************************************
  // Read mux
  // ************************************
  reg [7:0] rd_d;

  // Selects are one-hot, so an OR of gated bytes picks the addressed one
  always @* begin
    rd_d = gate(sel_dn1_hi, byte_of(dn1, 1'b1)) |
           gate(sel_dn1_lo, byte_of(dn1, 1'b0)) |
           gate(sel_dd1_hi, byte_of(dd1, 1'b1)) |
           gate(sel_dd1_lo, byte_of(dd1, 1'b0)) |
           gate(sel_wat_hi, byte_of(wat, 1'b1)) |
           gate(sel_wat_lo, byte_of(wat, 1'b0)) |
           gate(sel_hn0_hi, byte_of(hn0, 1'b1)) |
           gate(sel_hn0_lo, byte_of(hn0, 1'b0)) |
           gate(sel_hn1_hi, byte_of(hn1, 1'b1)) |
           gate(sel_hn1_lo, byte_of(hn1, 1'b0));
    if (sel_rsvd) begin
      rd_d = `AFCB_RST_RSVD;
    end
  end

  // ************************************
  // Read port
  // ************************************
  always @(posedge clock) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // Read data holds until the next read strobe
  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end
  end

endmodule

// ### dv/afcb_bank_props.sv
// Port assertions for the coefficient byte bank
// Assumes a bind onto afcb_bank, one clock, sync reset
`timescale 1ns/1ps
module afcb_bank_props (
  // Clock and reset
  input wire        clock,
  input wire        reset,
  // Register port
  input wire [6:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        reg_rvalid,
  // Coefficients
  input wire [15:0] deemph_r_numerator_one,
  input wire [15:0] deemph_r_denominator_one,
  input wire [15:0] widen_atten,
  input wire [15:0] hpf_l_numerator_zero,
  input wire [15:0] hpf_l_numerator_one
);
  wire        rsv = (reg_addr >= 7'h37) && (reg_addr <= 7'h40);
  wire        unm = !((reg_addr >= 7'h31) && (reg_addr <= 7'h36)) &&
                    !((reg_addr >= 7'h41) && (reg_addr <= 7'h44));
  wire [79:0] cf  = {deemph_r_numerator_one, deemph_r_denominator_one, widen_atten,
                     hpf_l_numerator_zero, hpf_l_numerator_one};
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_rst_values: assert property (disable iff (1'b0) reset |=> cf == 80'hF32D537E7FFF3955F32D)
    else $error("coefficients not at reset values");
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_no_spurious: assert property (!reg_rd |=> !reg_rvalid)
    else $error("rvalid without read");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("rdata moved without read");
  a_rsvd_zero: assert property (reg_rd && rsv |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  a_unmapped_ignored: assert property (reg_wr && unm |-> ##2 $stable(cf))
    else $error("unmapped write changed a coefficient");
  a_hi_lands: assert property (reg_wr && reg_addr == 7'h35 |-> ##2 widen_atten[15:8] == $past(reg_wdata, 2))
    else $error("high byte not in bits 15..8");
  a_lo_lands: assert property (reg_wr && reg_addr == 7'h36 |-> ##2 widen_atten[7:0] == $past(reg_wdata, 2))
    else $error("low byte not in bits 7..0");
  a_rd_matches: assert property (reg_rd && reg_addr == 7'h43 |=> reg_rdata == hpf_l_numerator_one[15:8])
    else $error("read back differs from coefficient");
endmodule
bind afcb_bank afcb_bank_props afcb_bank_props_inst (.clock(clock), .reset(reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .deemph_r_numerator_one(deemph_r_numerator_one),
  .deemph_r_denominator_one(deemph_r_denominator_one), .widen_atten(widen_atten),
  .hpf_l_numerator_zero(hpf_l_numerator_zero), .hpf_l_numerator_one(hpf_l_numerator_one));

// ### dv/afcb_bank_tb_top.sv
// Self-checking bench for the coefficient byte bank
// Assumes afcb_bank and its bound checker are compiled first
`timescale 1ns/1ps
module afcb_bank_tb_top;
  reg         clock = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  reg  [6:0]  reg_addr = 7'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  wire [7:0]  reg_rdata;
  wire        reg_rvalid;
  wire [15:0] c0, c1, c2, c3, c4;
  reg  [7:0]  m [0:127];
  int         n_fail = 0, n_checks = 0, seed = 32'h8909, cyc = 0, i, k;
  afcb_bank afcb_bank_inst (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .deemph_r_numerator_one(c0), .deemph_r_denominator_one(c1),
    .widen_atten(c2), .hpf_l_numerator_zero(c3), .hpf_l_numerator_one(c4));
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      conclude;
    end
  end
  // ************
  // Model and checks
  // ************
  task rinit;
    for (i = 0; i < 128; i++) m[i] = 8'h00;
    {m[49], m[50], m[51], m[52], m[53], m[54]} = 48'hF32D537E7FFF;
    {m[65], m[66], m[67], m[68]} = 32'h3955F32D;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clock);
    reg_wr = 0;
    if ((a > 7'h30 && a < 7'h37) || (a > 7'h40 && a < 7'h45)) m[a] = d;
  endtask
  task rd(input [6:0] a);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clock);
    reg_rd = 0;
    chk({7'h00, reg_rvalid}, 16'h0001);
    chk({8'h00, reg_rdata}, {8'h00, m[a]});
  endtask
  task ck;
    @(negedge clock);
    chk(c0, {m[49], m[50]});
    chk(c1, {m[51], m[52]});
    chk(c2, {m[53], m[54]});
    chk(c3, {m[65], m[66]});
    chk(c4, {m[67], m[68]});
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ************
  // Main sequence
  // ************
  initial begin
    rinit;
    repeat (4) @(negedge clock);
    reset = 0;
    ck;
    for (k = 8'h30; k < 8'h46; k++) rd(k);
    $display("reset values done");
    wr(7'h30, $random(seed));
    for (k = 8'h45; k < 8'h50; k++) wr(k, $random(seed));
    for (k = 8'h30; k < 8'h50; k++) rd(k);
    ck;
    $display("reserved done");
    repeat (6) begin
      for (k = 8'h31; k < 8'h45; k++) if (k < 8'h37 || k > 8'h40) wr(k, $random(seed));
      ck;
      for (k = 8'h31; k < 8'h45; k++) rd(k);
    end
    $display("write readback done");
    reset = 1;
    repeat (2) @(negedge clock);
    reset = 0;
    rinit;
    ck;
    $display("second reset done");
    conclude;
  end
endmodule
